// ---- verilog/pcs_cfg_defines.vh ----
// Purpose: Constants for the PCS sub-layer configuration register block
// Assumes: 16-bit management registers addressed by a 5-bit register number
// Notes:   Field positions are bit indices within the control word; STATUS_PRE_SUPP_BIT is in the status word
`ifndef PCS_CFG_DEFINES_VH
`define PCS_CFG_DEFINES_VH

`define PCS_CTRL_ADDR        5'h17
`define BASIC_STATUS_ADDR    5'h01
`define LEGACY_CFG_ADDR      5'h1C

`define BIT_NRZI_EN          15
`define BIT_TIMEOUT_SEL      14
`define BIT_TIMEOUT_DIS      13
`define BIT_REPEATER         12
`define BIT_LED5_MODE        11
`define BIT_UNLOCK           10
`define BIT_PREAMBLE_REQ     9
`define BIT_FAST_TEST        8
`define BIT_CLK_OFF          7
`define BIT_LINK_CHECK       6
`define BIT_CIM_OFF          5
`define BIT_TX_OFF           4

`define LEGACY_BIT           0
`define STATUS_PRE_SUPP_BIT  6

`define PREAMBLE_ONES        6'h20
`define FAST_DIV_NORMAL      8'h64
`define FAST_DIV_TEST        8'h01
`define BASIC_STATUS_BASE    16'h7849

`endif

// ---- verilog/tx_gate.v ----
// Purpose: Gate transmit enable on clean packet boundaries
// Assumes: tx_en_in synchronous to mclk_in
// Notes:   Gate state only changes while tx_en_in is low
`timescale 1ns/1ps
module tx_gate (
    input  wire mclk_in,
    input  wire resetn_in,
    input  wire tx_off_in,
    input  wire tx_en_in,
    output wire tx_en_out,
    output wire tx_blocked_out
);
    reg blocked_reg;
    wire blocked_next;

    ////////////////////////////////////////////////////////////////
    // Track disable only between packets
    // Finish current packet
    assign blocked_next = tx_en_in ? blocked_reg : tx_off_in;

    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            blocked_reg <= 1'b0;
        end else begin
            blocked_reg <= blocked_next;
        end
    end

    assign tx_en_out      = tx_en_in & ~blocked_reg & ~(tx_off_in & ~tx_en_in);
    assign tx_blocked_out = blocked_reg;
endmodule

// ---- verilog/preamble_check.v ----
// Purpose: Count leading ones before a management frame start
// Assumes: bit_valid_in marks one sampled data bit per pulse
// Notes:   Saturating counter avoids wrap on long idle
`timescale 1ns/1ps
`include "pcs_cfg_defines.vh"
module preamble_check #(
    parameter [5:0] ONES_NEEDED = `PREAMBLE_ONES
) (
    input  wire mclk_in,
    input  wire resetn_in,
    input  wire bit_valid_in,
    input  wire bit_in,
    output wire preamble_seen_out
);
    reg  [5:0] ones_reg;
    wire [5:0] ones_next;

    ////////////////////////////////////////////////////////////////
    // Saturating count of contiguous ones
    // Count 32 ones
    assign ones_next = !bit_valid_in ? ones_reg :
                       !bit_in ? 6'h00 :
                       (ones_reg == ONES_NEEDED) ? ones_reg : ones_reg + 6'h01;

    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            ones_reg <= 6'h00;
        end else begin
            ones_reg <= ones_next;
        end
    end

    assign preamble_seen_out = (ones_reg == ONES_NEEDED);
endmodule

// ---- verilog/pcs_sublayer_config_register.v ----
// Purpose: PCS sub-layer configuration register with its control effects
// Assumes: Management frame decoder supplies register number and strobes
// Notes:   Bits 3..0 are stored plainly; their effects live elsewhere
`timescale 1ns/1ps
`include "pcs_cfg_defines.vh"
module pcs_sublayer_config_register (
    input  wire        mclk_in,
    input  wire        resetn_in,
    input  wire        test_mode_pin_in,
    input  wire        repeater_pin_in,
    input  wire [4:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire [15:0] reg_wdata_in,
    output reg  [15:0] reg_rdata_out,
    input  wire        legacy_mode_in,
    input  wire        mgmt_bit_valid_in,
    input  wire        mgmt_bit_in,
    input  wire        mgmt_frame_start_in,
    output wire        mgmt_frame_ok_out,
    input  wire        clock_out_25mhz_in,
    output wire        clock_out_25mhz_out,
    output wire        clock_out_25mhz_oe_out,
    input  wire        link_raw_in,
    output wire        link_ok_out,
    output wire        link_speed_100_out,
    output wire        link_led_out,
    input  wire        link_unstable_in,
    output wire        rx_enable_out,
    input  wire        tx_en_in,
    output wire        tx_en_out,
    input  wire        rx_active_in,
    output wire        crs_out,
    output wire        nrzi_enable_out,
    output reg         timer_tick_out
);
    reg  [15:0] ctrl_reg;
    reg  [15:0] ctrl_next;
    reg         strap_done_reg;
    reg         cim_trip_reg;
    reg  [7:0]  tick_cnt_reg;
    wire [7:0]  tick_limit;
    wire        preamble_seen;
    wire        tx_blocked;
    wire        tx_gated;
    wire        pre_req;
    wire        fast_test;
    wire [15:0] status_word;

    ////////////////////////////////////////////////////////////////
    // Effective values, masked in legacy mode
    // Legacy forces clear
    assign pre_req   = ctrl_reg[`BIT_PREAMBLE_REQ] & ~legacy_mode_in;
    assign fast_test = ctrl_reg[`BIT_FAST_TEST] & ~legacy_mode_in;

    ////////////////////////////////////////////////////////////////
    // Register write path
    always @* begin
        ctrl_next = ctrl_reg;
        if (reg_wr_in && reg_addr_in == `PCS_CTRL_ADDR) begin
            ctrl_next = reg_wdata_in;
            if (legacy_mode_in) begin
                ctrl_next[`BIT_PREAMBLE_REQ] = 1'b0;
                ctrl_next[`BIT_FAST_TEST]    = 1'b0;
            end
        end
    end

    // Straps caught on first clocked cycle after reset release
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            ctrl_reg       <= 16'h8040;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            ctrl_reg       <= ctrl_reg;
            ctrl_reg[`BIT_CLK_OFF]  <= ~test_mode_pin_in;
            ctrl_reg[`BIT_CIM_OFF]  <= ~repeater_pin_in;
            ctrl_reg[`BIT_REPEATER] <= repeater_pin_in;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read path, registered data
    // Inverse preamble status
    assign status_word = (`BASIC_STATUS_BASE & ~(16'h0001 << `STATUS_PRE_SUPP_BIT))
                         | ({15'h0000, ~pre_req} << `STATUS_PRE_SUPP_BIT);

    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 16'h0000;
        end else begin
            case (reg_addr_in)
                `PCS_CTRL_ADDR: begin
                    reg_rdata_out <= {ctrl_reg[15:10], pre_req, fast_test, ctrl_reg[7:0]};
                end
                `BASIC_STATUS_ADDR: begin
                    reg_rdata_out <= status_word;
                end
                default: begin
                    reg_rdata_out <= 16'h0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Management frame acceptance
    preamble_check #(
        .ONES_NEEDED (`PREAMBLE_ONES)
    ) u_pre (
        .mclk_in           (mclk_in),
        .resetn_in         (resetn_in),
        .bit_valid_in      (mgmt_bit_valid_in),
        .bit_in            (mgmt_bit_in),
        .preamble_seen_out (preamble_seen)
    );

    assign mgmt_frame_ok_out = mgmt_frame_start_in & (~pre_req | preamble_seen);

    ////////////////////////////////////////////////////////////////
    // Timer tick prescaler, sped up in fast test
    // Fast timer divider
    assign tick_limit = fast_test ? `FAST_DIV_TEST : `FAST_DIV_NORMAL;

    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            tick_cnt_reg   <= 8'h00;
            timer_tick_out <= 1'b0;
        end else if (tick_cnt_reg >= tick_limit - 8'h01) begin
            tick_cnt_reg   <= 8'h00;
            timer_tick_out <= 1'b1;
        end else begin
            tick_cnt_reg   <= tick_cnt_reg + 8'h01;
            timer_tick_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Clock output drive; off bit cuts both level and enable
    // Tri-state clock output
    assign clock_out_25mhz_out    = clock_out_25mhz_in & ~ctrl_reg[`BIT_CLK_OFF];
    assign clock_out_25mhz_oe_out = ~ctrl_reg[`BIT_CLK_OFF];

    ////////////////////////////////////////////////////////////////
    // Link forcing
    // Force link OK
    assign link_ok_out        = ctrl_reg[`BIT_LINK_CHECK] ? link_raw_in : 1'b1;
    assign link_speed_100_out = ~ctrl_reg[`BIT_LINK_CHECK];
    assign link_led_out       = link_ok_out;

    ////////////////////////////////////////////////////////////////
    // Carrier integrity monitor trip, sticky until monitor off
    // Unstable link blocks
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            cim_trip_reg <= 1'b0;
        end else if (ctrl_reg[`BIT_CIM_OFF]) begin
            cim_trip_reg <= 1'b0;
        end else if (link_unstable_in) begin
            cim_trip_reg <= 1'b1;
        end
    end

    assign rx_enable_out = ~cim_trip_reg;

    ////////////////////////////////////////////////////////////////
    // Transmit gating on packet boundaries
    tx_gate u_txg (
        .mclk_in        (mclk_in),
        .resetn_in      (resetn_in),
        .tx_off_in      (ctrl_reg[`BIT_TX_OFF]),
        .tx_en_in       (tx_en_in),
        .tx_en_out      (tx_gated),
        .tx_blocked_out (tx_blocked)
    );

    assign tx_en_out = tx_gated & ~cim_trip_reg;

    ////////////////////////////////////////////////////////////////
    // Carrier sense source select
    // Repeater carrier sense
    assign crs_out = ctrl_reg[`BIT_REPEATER] ? rx_active_in : (rx_active_in | (tx_en_in & ~tx_blocked));

    assign nrzi_enable_out = ctrl_reg[`BIT_NRZI_EN];
endmodule

// ---- tb/pcs_cfg_props.sv ----
// Purpose: Port-level properties of the config register block
// Assumes: One clock, synchronous active-low reset
// Notes:   Counters stand in for long runs of ones and quiet spans
`timescale 1ns/1ps
module pcs_cfg_props (
    input wire        mclk_in, resetn_in, reg_wr_in, legacy_mode_in, mgmt_bit_valid_in, mgmt_bit_in,
    input wire        mgmt_frame_start_in, mgmt_frame_ok_out, clock_out_25mhz_in, clock_out_25mhz_out,
    input wire        clock_out_25mhz_oe_out, tx_en_in, tx_en_out, rx_active_in, crs_out, timer_tick_out,
    input wire [4:0]  reg_addr_in,
    input wire [15:0] reg_rdata_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    reg [5:0] ones_reg;
    reg [6:0] gap_reg;
    // Saturating so a long idle never wraps back under the limit
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            ones_reg <= 6'h00;
            gap_reg  <= 7'h00;
        end else begin
            if (mgmt_bit_valid_in)
                ones_reg <= mgmt_bit_in ? ones_reg + {5'h00, ones_reg != 6'h3F} : 6'h00;
            gap_reg <= timer_tick_out ? 7'h00 : gap_reg + {6'h00, gap_reg != 7'h7F};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence busy_s; tx_en_in && tx_en_out; endsequence
    sequence shut_s; tx_en_in && !tx_en_out; endsequence
    // Status read then control read, legacy steady between
    sequence stat_ctrl_s;
        (reg_addr_in == 5'h01 && !reg_wr_in) ##1 (reg_addr_in == 5'h17 && !reg_wr_in && $stable(legacy_mode_in));
    endsequence
    frame_pre_a: assert property ((mgmt_frame_start_in && ones_reg >= 6'h20) |-> mgmt_frame_ok_out)
        else $error("frame with preamble refused");
    status_inv_a: assert property (stat_ctrl_s |=> reg_rdata_out[9] != $past(reg_rdata_out[6]))
        else $error("status bit not inverse");
    legacy_ro_a: assert property ((legacy_mode_in && reg_addr_in == 5'h17) |=> reg_rdata_out[9:8] == 2'b00)
        else $error("legacy bits not clear");
    tx_finish_a: assert property (busy_s ##1 tx_en_in |-> tx_en_out)
        else $error("packet cut short");
    tx_hold_a: assert property (shut_s ##1 tx_en_in |-> !tx_en_out)
        else $error("fragment sent");
    clk_gate_a: assert property (clock_out_25mhz_oe_out |-> clock_out_25mhz_out == clock_out_25mhz_in)
        else $error("clock output wrong");
    tick_gap_a: assert property (gap_reg <= 7'h65)
        else $error("timer tick missing");
    crs_src_a: assert property (crs_out |-> (rx_active_in || tx_en_in))
        else $error("carrier without activity");
endmodule
bind pcs_sublayer_config_register pcs_cfg_props u_props (.*);

// ---- tb/mgmt_station_model.sv ----
// Purpose: Station manager making register cycles and management bits
// Assumes: Requests change on the falling clock edge
// Notes:   Released data lines carry the inverse of their last value
`timescale 1ns/1ps
module mgmt_station_model (
    input  wire        mclk_in,
    input  wire [15:0] rdata_in,
    input  wire        frame_ok_in,
    output reg  [4:0]  addr_out = 5'h00,
    output reg         wr_out = 1'b0,
    output reg  [15:0] wdata_out = 16'h0000,
    output reg         bit_valid_out = 1'b0,
    output reg         bit_out = 1'b0,
    output reg         start_out = 1'b0
);
    // One-cycle write strobe to the control word
    task wr(input [15:0] v);
        begin
            @(negedge mclk_in) begin addr_out = 5'h17; wdata_out = v; wr_out = 1'b1; end
            @(negedge mclk_in) begin wr_out = 1'b0; wdata_out = ~v; end
        end
    endtask
    task rd(input [4:0] a, output [15:0] v);
        begin
            @(negedge mclk_in) addr_out = a;
            @(negedge mclk_in) v = rdata_in;
        end
    endtask
    task bits(input integer k, input b);
        begin
            repeat (k) @(negedge mclk_in) begin bit_valid_out = 1'b1; bit_out = b; end
            @(negedge mclk_in) begin bit_valid_out = 1'b0; bit_out = ~b; end
        end
    endtask
    task start(output f);
        begin
            @(negedge mclk_in) start_out = 1'b1;
            #5 f = frame_ok_in;
            @(negedge mclk_in) start_out = 1'b0;
        end
    endtask
endmodule

// ---- tb/pcs_sublayer_config_register_test.sv ----
// Purpose: Self-checking bench for the config register block
// Assumes: Inputs change on the falling clock edge
// Notes:   Random words come from a fixed xorshift seed
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("MISMATCH t=%0t %h %h", $time, a, b); end end
module pcs_sublayer_config_register_test;
    reg         mclk_in = 1'b0, resetn_in = 1'b0, clock_out_25mhz = 1'b0, legacy = 1'b0, f;
    reg         link_raw = 1'b0, unstable = 1'b0, tx_en = 1'b0, rx_act = 1'b0, tmode = 1'b0, rep = 1'b0;
    reg  [31:0] seed = 32'h0001_6F0A;
    reg  [15:0] d, q, s, e;
    integer     err_total = 0, checked = 0, i, n;
    wire [15:0] rdata, wd;
    wire [4:0]  addr;
    wire        wr, bv, bt, fs, ok, c25, oe, lok, spd, led, rxe, txo, crs, nrzi, tick;
    always #25 mclk_in = ~mclk_in;
    always @(negedge mclk_in) clock_out_25mhz <= ~clock_out_25mhz;
    pcs_sublayer_config_register u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .test_mode_pin_in(tmode),
        .repeater_pin_in(rep), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rdata),
        .legacy_mode_in(legacy), .mgmt_bit_valid_in(bv), .mgmt_bit_in(bt), .mgmt_frame_start_in(fs),
        .mgmt_frame_ok_out(ok), .clock_out_25mhz_in(clock_out_25mhz), .clock_out_25mhz_out(c25), .clock_out_25mhz_oe_out(oe),
        .link_raw_in(link_raw), .link_ok_out(lok), .link_speed_100_out(spd), .link_led_out(led),
        .link_unstable_in(unstable), .rx_enable_out(rxe), .tx_en_in(tx_en), .tx_en_out(txo),
        .rx_active_in(rx_act), .crs_out(crs), .nrzi_enable_out(nrzi), .timer_tick_out(tick));
    mgmt_station_model u_host (.mclk_in(mclk_in), .rdata_in(rdata), .frame_ok_in(ok), .addr_out(addr),
        .wr_out(wr), .wdata_out(wd), .bit_valid_out(bv), .bit_out(bt), .start_out(fs));
    ////////////////////////////////////////////////////////////////////////////////
    function [31:0] xs(input [31:0] v);
        xs = v ^ (v << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    // Legacy mode forces the two locked bits to zero
    function [15:0] exp_ctrl(input [15:0] v, input lg);
        exp_ctrl = lg ? (v & 16'hFCFF) : v;
    endfunction
    task cyc(input integer k); repeat (k) @(negedge mclk_in); endtask
    task chk_wr(input [15:0] v, input lg);
        begin
            legacy = lg;
            u_host.wr(v);
            u_host.rd(5'h01, s);
            u_host.rd(5'h17, q);
            e = exp_ctrl(v, lg);
            `CHK(q, e)
            `CHK(s[6], ~e[9])
            `CHK({nrzi, oe}, {v[15], ~v[7]})
        end
    endtask
    task final_report;
        begin
            $display("errors %0d checks %0d", err_total, checked);
            if (err_total == 0 && checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #(20000 * 50);
        err_total++;
        final_report;
    end
    // Main sequence: reset values, random words, then each control effect
    initial begin
        cyc(12);
        resetn_in = 1'b1;
        cyc(2);
        u_host.rd(5'h17, q);
        `CHK({q, oe}, {16'h80E0, 1'b0})
        for (i = 0; i < 18; i++) begin
            seed = xs(seed);
            link_raw = seed[16];
            rx_act = seed[17];
            d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
            chk_wr(d, seed[20] | (i == 0));
        end
        chk_wr(16'h0240, 1'b0);
        u_host.bits(31, 1'b1);
        u_host.start(f);
        `CHK(f, 1'b0)
        u_host.bits(1, 1'b1);
        u_host.start(f);
        `CHK(f, 1'b1)
        u_host.bits(2, 1'b0);
        chk_wr(16'h0040, 1'b0);
        u_host.start(f);
        `CHK(f, 1'b1)
        tx_en = 1'b1;
        cyc(2);
        `CHK(txo, 1'b1)
        u_host.wr(16'h0050);
        cyc(2);
        `CHK(txo, 1'b1)
        tx_en = 1'b0;
        cyc(2);
        tx_en = 1'b1;
        cyc(1);
        `CHK(txo, 1'b0)
        u_host.wr(16'h0040);
        cyc(2);
        `CHK(txo, 1'b0)
        tx_en = 1'b0;
        cyc(1);
        tx_en = 1'b1;
        cyc(1);
        `CHK({txo, crs}, 2'b11)
        rx_act = 1'b0;
        u_host.wr(16'h1040);
        cyc(1);
        `CHK(crs, 1'b0)
        tx_en = 1'b0;
        link_raw = 1'b0;
        u_host.wr(16'h0000);
        cyc(1);
        `CHK({lok, spd, led}, 3'b111)
        u_host.wr(16'h0040);
        cyc(1);
        `CHK(lok, 1'b0)
        unstable = 1'b1;
        cyc(2);
        unstable = 1'b0;
        cyc(2);
        `CHK(rxe, 1'b0)
        u_host.wr(16'h0060);
        cyc(2);
        `CHK(rxe, 1'b1)
        for (i = 0; i < 3; i++) begin
            legacy = (i == 2);
            u_host.wr(i == 1 ? 16'h0040 : 16'h0140);
            cyc(3);
            n = 0;
            repeat (200) begin cyc(1); n = n + tick; end
            `CHK(n, (i == 0) ? 200 : 2)
        end
        // Second reset with both straps high
        legacy = 1'b0;
        tmode = 1'b1;
        rep = 1'b1;
        resetn_in = 1'b0;
        cyc(12);
        resetn_in = 1'b1;
        cyc(2);
        u_host.rd(5'h17, q);
        `CHK({q, oe}, {16'h9040, 1'b1})
        final_report;
    end
endmodule
